// ===== hdl/upper_bank_special_registers.sv
// Purpose: Upper special register bank behind an APB slave
// Assumes: Sync reset, reset class given by reset_power_class and reset_brownout
// Notes:   Zero wait states, read data captured in the setup cycle
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module upper_bank_special_registers (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   reset_power_class,
  input  wire logic                   reset_brownout,
  input  wire logic [1:0]             wake_flags,
  input  wire logic                   tx_shift_empty,
  input  wire logic [5:0]             serial_state,
  input  wire logic                   pc_advance,
  input  wire sfr_bank_pkg::apb_req_t apb,
  output logic                        pready,
  output logic      [31:0]            prdata,
  output logic                        pslverr,
  output logic      [12:0]            program_counter,
  output sfr_bank_pkg::sfr_view_t     sfr
);

  logic [7:0]  option_reg;
  logic [7:0]  status_reg;
  logic [7:0]  pointer_reg;
  logic [5:0]  tris_a_reg;
  logic [7:0]  tris_b_reg;
  logic [7:0]  tris_c_reg;
  logic [4:0]  pc_high_latch_reg;
  logic [7:0]  intctl_reg;
  logic [7:0]  pie_one_reg;
  logic [0:0]  pie_two_reg;
  logic [1:0]  pwr_reg;
  logic [7:0]  period_reg;
  logic [7:0]  ssp_addr_reg;
  logic [7:0]  tx_ctl_reg;
  logic [7:0]  baud_reg;
  logic [7:0]  raw_idx;
  logic [7:0]  reg_idx;
  logic        mirrored;
  logic        mapped;
  logic        setup;
  logic        access;
  logic        wr;
  logic [7:0]  wbyte;
  logic [7:0]  mem_rdata;
  logic        mem_we;
  logic [7:0]  read_next;

  assign raw_idx = apb.paddr[sfr_bank_pkg::ADDR_W-1:2];
  assign setup   = apb.psel && !apb.penable && ce;
  assign access  = apb.psel && apb.penable;
  assign pready  = access && ce;
  assign pslverr = 1'b0;
  assign wr      = pready && apb.pwrite;
  assign wbyte   = apb.pwdata[7:0];

  always_comb
  begin
    case (raw_idx)
      8'h00, 8'h02, 8'h03, 8'h04, 8'h0a, 8'h0b: mirrored = 1'b1;
      default:                                  mirrored = 1'b0;
    endcase
    reg_idx = mirrored ? (raw_idx | sfr_bank_pkg::UPPER_BANK) : raw_idx;
  end

  always_comb
  begin
    mapped    = 1'b1;
    read_next = 8'h00;
    case (reg_idx)
      sfr_bank_pkg::IDX_WINDOW:   read_next = mem_rdata;
      sfr_bank_pkg::IDX_OPTION:   read_next = option_reg;
      sfr_bank_pkg::IDX_PCL:      read_next = program_counter[7:0];
      sfr_bank_pkg::IDX_STATUS:   read_next = status_reg;
      sfr_bank_pkg::IDX_POINTER:  read_next = pointer_reg;
      sfr_bank_pkg::IDX_TRIS_A:   read_next = {2'b00, tris_a_reg};
      sfr_bank_pkg::IDX_TRIS_B:   read_next = tris_b_reg;
      sfr_bank_pkg::IDX_TRIS_C:   read_next = tris_c_reg;
      sfr_bank_pkg::IDX_PC_HIGH_LATCH:   read_next = {3'b000, pc_high_latch_reg};
      sfr_bank_pkg::IDX_INTCTL:   read_next = intctl_reg;
      sfr_bank_pkg::IDX_PIE_ONE:  read_next = pie_one_reg;
      sfr_bank_pkg::IDX_PIE_TWO:  read_next = {7'h00, pie_two_reg};
      sfr_bank_pkg::IDX_PWRFLAGS: read_next = {6'h00, pwr_reg};
      sfr_bank_pkg::IDX_PERIOD:   read_next = period_reg;
      sfr_bank_pkg::IDX_SSP_ADDR: read_next = ssp_addr_reg;
      sfr_bank_pkg::IDX_SSP_STAT: read_next = {2'b00, serial_state};
      sfr_bank_pkg::IDX_TX_CTL:
        read_next = {tx_ctl_reg[7:4], 1'b0, tx_ctl_reg[2], tx_shift_empty, tx_ctl_reg[0]};
      sfr_bank_pkg::IDX_BAUD:     read_next = baud_reg;
      default:                    mapped = 1'b0;
    endcase
  end

  // Read data captured at setup
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (rst)
        prdata <= 32'h0000_0000;
      else if (setup && !apb.pwrite)
        prdata <= {24'h00_0000, read_next};
    end
  end

  assign mem_we = wr && (reg_idx == sfr_bank_pkg::IDX_WINDOW);

  indirect_data_memory u_mem (
    .clk   (clk),
    .ce    (ce),
    .wr_en (mem_we),
    .addr  ({status_reg[sfr_bank_pkg::STATUS_IRP], pointer_reg}),
    .wdata (wbyte),
    .rdata (mem_rdata)
  );

  program_counter_unit u_pc (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .pcl_write (wr && (reg_idx == sfr_bank_pkg::IDX_PCL)),
    .pcl_wdata (wbyte),
    .latch     (pc_high_latch_reg),
    .advance   (pc_advance),
    .pc        (program_counter)
  );

  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (rst && reset_power_class)
      begin
        status_reg  <= sfr_bank_pkg::RST_STATUS;
        pointer_reg <= sfr_bank_pkg::RST_POINTER;
        intctl_reg  <= sfr_bank_pkg::RST_INTCTL;
        pc_high_latch_reg  <= sfr_bank_pkg::RST_PC_HIGH_LATCH;
      end
      else if (rst)
      begin
        status_reg  <= {3'b000, wake_flags, status_reg[2:0]};
        intctl_reg  <= {7'h00, intctl_reg[0]};
        pc_high_latch_reg  <= sfr_bank_pkg::RST_PC_HIGH_LATCH;
      end
      else if (wr)
      begin
        case (reg_idx)
          sfr_bank_pkg::IDX_STATUS:
            status_reg <= (wbyte & sfr_bank_pkg::STATUS_WMASK)
                        | (status_reg & ~sfr_bank_pkg::STATUS_WMASK);
          sfr_bank_pkg::IDX_POINTER: pointer_reg <= wbyte;
          sfr_bank_pkg::IDX_INTCTL:  intctl_reg  <= wbyte;
          sfr_bank_pkg::IDX_PC_HIGH_LATCH:  pc_high_latch_reg  <= wbyte[4:0];
          default:                   pointer_reg <= pointer_reg;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (rst)
      begin
        option_reg   <= sfr_bank_pkg::RST_OPTION;
        tris_a_reg   <= sfr_bank_pkg::RST_TRIS_A;
        tris_b_reg   <= sfr_bank_pkg::RST_TRIS_B;
        tris_c_reg   <= sfr_bank_pkg::RST_TRIS_C;
        pie_one_reg  <= sfr_bank_pkg::RST_PIE_ONE;
        pie_two_reg  <= sfr_bank_pkg::RST_PIE_TWO;
        period_reg   <= sfr_bank_pkg::RST_PERIOD;
        ssp_addr_reg <= sfr_bank_pkg::RST_SSP_ADDR;
        tx_ctl_reg   <= sfr_bank_pkg::RST_TX_CTL;
        baud_reg     <= sfr_bank_pkg::RST_BAUD;
      end
      else if (wr)
      begin
        case (reg_idx)
          sfr_bank_pkg::IDX_OPTION:   option_reg   <= wbyte;
          sfr_bank_pkg::IDX_TRIS_A:   tris_a_reg   <= wbyte[5:0];
          sfr_bank_pkg::IDX_TRIS_B:   tris_b_reg   <= wbyte;
          sfr_bank_pkg::IDX_TRIS_C:   tris_c_reg   <= wbyte;
          sfr_bank_pkg::IDX_PIE_ONE:  pie_one_reg  <= wbyte;
          sfr_bank_pkg::IDX_PIE_TWO:  pie_two_reg  <= wbyte[0];
          sfr_bank_pkg::IDX_PERIOD:   period_reg   <= wbyte;
          sfr_bank_pkg::IDX_SSP_ADDR: ssp_addr_reg <= wbyte;
          sfr_bank_pkg::IDX_TX_CTL:   tx_ctl_reg   <= wbyte & sfr_bank_pkg::TX_CTL_WMASK;
          sfr_bank_pkg::IDX_BAUD:     baud_reg     <= wbyte;
          default:                    baud_reg     <= baud_reg;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (rst && reset_power_class)
      begin
        pwr_reg[sfr_bank_pkg::PWR_POR] <= reset_brownout ? pwr_reg[sfr_bank_pkg::PWR_POR] : 1'b0;
        pwr_reg[sfr_bank_pkg::PWR_BOR] <= 1'b0;
      end
      else if (!rst && wr && (reg_idx == sfr_bank_pkg::IDX_PWRFLAGS))
        pwr_reg <= wbyte[1:0];
    end
  end

  assign sfr = '{option_config:             option_reg,
                 core_status_flags:         status_reg,
                 indirect_pointer:          pointer_reg,
                 port_a_direction:          tris_a_reg,
                 port_b_direction:          tris_b_reg,
                 port_c_direction:          tris_c_reg,
                 pc_high_latch:             pc_high_latch_reg,
                 interrupt_control:         intctl_reg,
                 peripheral_irq_enable_one: pie_one_reg,
                 peripheral_irq_enable_two: pie_two_reg,
                 power_reset_flags:         pwr_reg,
                 timer_period:              period_reg,
                 serial_slave_address:      ssp_addr_reg,
                 serial_tx_control:         tx_ctl_reg,
                 baud_divisor:              baud_reg};

  property p_unmapped_read_zero;
    @(posedge clk) disable iff (rst)
    (setup && !apb.pwrite && !mapped) |=> (prdata == 32'h0000_0000);
  endproperty
  a_unmapped_read_zero: assert property (p_unmapped_read_zero) else $error("unmapped read not zero");

  property p_unmapped_write_inert;
    @(posedge clk) disable iff (rst)
    (wr && !mapped && !pc_advance) |=> $stable(sfr) && $stable(program_counter[12:8]);
  endproperty
  a_unmapped_write_inert: assert property (p_unmapped_write_inert) else $error("unmapped write changed state");

  property p_tris_a_top_zero;
    @(posedge clk) disable iff (rst)
    (setup && !apb.pwrite && reg_idx == sfr_bank_pkg::IDX_TRIS_A) |=> (prdata[7:6] == 2'b00);
  endproperty
  a_tris_a_top_zero: assert property (p_tris_a_top_zero) else $error("unused direction bits read set");

  property p_mirror_status;
    @(posedge clk) disable iff (rst)
    (setup && !apb.pwrite && apb.paddr[9:2] == 8'h03) |=> (prdata[7:0] == $past(status_reg));
  endproperty
  a_mirror_status: assert property (p_mirror_status) else $error("lower copy of status differs");

  property p_mirror_pointer_write;
    @(posedge clk) disable iff (rst)
    (wr && apb.paddr[9:2] == 8'h04) |=> (pointer_reg == $past(wbyte));
  endproperty
  a_mirror_pointer_write: assert property (p_mirror_pointer_write) else $error("lower pointer write lost");

  property p_por_values;
    @(posedge clk) disable iff (!ce)
    (rst && reset_power_class) |=> (option_reg == sfr_bank_pkg::RST_OPTION)
      && (status_reg == sfr_bank_pkg::RST_STATUS) && (pwr_reg[sfr_bank_pkg::PWR_BOR] == 1'b0);
  endproperty
  a_por_values: assert property (p_por_values) else $error("power-on values wrong");

  property p_other_reset_keeps;
    @(posedge clk) disable iff (!ce)
    (rst && !reset_power_class) |=> $stable(pointer_reg) && $stable(pwr_reg)
      && (status_reg[2:0] == $past(status_reg[2:0])) && (status_reg[4:3] == $past(wake_flags));
  endproperty
  a_other_reset_keeps: assert property (p_other_reset_keeps) else $error("other reset lost contents");

  logic       win_valid_reg;
  logic [8:0] win_addr_reg;
  logic [7:0] win_data_reg;

  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (rst)
        win_valid_reg <= 1'b0;
      else if (mem_we)
      begin
        win_valid_reg <= 1'b1;
        win_addr_reg  <= {status_reg[sfr_bank_pkg::STATUS_IRP], pointer_reg};
        win_data_reg  <= wbyte;
      end
    end
  end

  property p_window_redirect;
    @(posedge clk) disable iff (rst)
    (setup && !apb.pwrite && reg_idx == sfr_bank_pkg::IDX_WINDOW && win_valid_reg
      && ({status_reg[sfr_bank_pkg::STATUS_IRP], pointer_reg} == win_addr_reg))
      |=> (prdata[7:0] == $past(win_data_reg));
  endproperty
  a_window_redirect: assert property (p_window_redirect) else $error("window did not reach memory");

  property p_zero_wait;
    @(posedge clk) disable iff (rst)
    (access && ce) |-> pready && !pslverr;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("access not answered at once");

  c_mirror_read: cover property (@(posedge clk) setup && mirrored && !apb.pwrite);
  c_window_write: cover property (@(posedge clk) mem_we);
  c_other_reset: cover property (@(posedge clk) ce && rst && !reset_power_class);
  c_pcl_jump: cover property (@(posedge clk) wr && reg_idx == sfr_bank_pkg::IDX_PCL);

endmodule : upper_bank_special_registers

// ===== common/sfr_bank_pkg.sv
// Purpose: Constants and carriers for the upper special register bank
// Assumes: APB with 32-bit data, register index = byte address / 4
// Notes:   Printed offsets are register indexes
package sfr_bank_pkg;

  localparam int ADDR_W = 10;
  localparam int MEM_AW = 9;

  // Register indexes
  localparam logic [7:0] IDX_WINDOW   = 8'h80;
  localparam logic [7:0] IDX_OPTION   = 8'h81;
  localparam logic [7:0] IDX_PCL      = 8'h82;
  localparam logic [7:0] IDX_STATUS   = 8'h83;
  localparam logic [7:0] IDX_POINTER  = 8'h84;
  localparam logic [7:0] IDX_TRIS_A   = 8'h85;
  localparam logic [7:0] IDX_TRIS_B   = 8'h86;
  localparam logic [7:0] IDX_TRIS_C   = 8'h87;
  localparam logic [7:0] IDX_PC_HIGH_LATCH   = 8'h8a;
  localparam logic [7:0] IDX_INTCTL   = 8'h8b;
  localparam logic [7:0] IDX_PIE_ONE  = 8'h8c;
  localparam logic [7:0] IDX_PIE_TWO  = 8'h8d;
  localparam logic [7:0] IDX_PWRFLAGS = 8'h8e;
  localparam logic [7:0] IDX_PERIOD   = 8'h92;
  localparam logic [7:0] IDX_SSP_ADDR = 8'h93;
  localparam logic [7:0] IDX_SSP_STAT = 8'h94;
  localparam logic [7:0] IDX_TX_CTL   = 8'h98;
  localparam logic [7:0] IDX_BAUD     = 8'h99;
  localparam logic [7:0] UPPER_BANK   = 8'h80;

  // Power-on / brown-out values
  localparam logic [7:0] RST_OPTION   = 8'hff;
  localparam logic [7:0] RST_STATUS   = 8'h18;
  localparam logic [7:0] RST_POINTER  = 8'h00;
  localparam logic [5:0] RST_TRIS_A   = 6'h3f;
  localparam logic [7:0] RST_TRIS_B   = 8'hff;
  localparam logic [7:0] RST_TRIS_C   = 8'hff;
  localparam logic [4:0] RST_PC_HIGH_LATCH   = 5'h00;
  localparam logic [7:0] RST_INTCTL   = 8'h00;
  localparam logic [7:0] RST_PIE_ONE  = 8'h00;
  localparam logic [0:0] RST_PIE_TWO  = 1'h0;
  localparam logic [7:0] RST_PERIOD   = 8'hff;
  localparam logic [7:0] RST_SSP_ADDR = 8'h00;
  localparam logic [7:0] RST_TX_CTL   = 8'h02;
  localparam logic [7:0] RST_BAUD     = 8'h00;
  localparam logic [12:0] RST_PC      = 13'h0000;

  // Field positions and write masks
  localparam int STATUS_TO  = 4;
  localparam int STATUS_PD  = 3;
  localparam int STATUS_IRP = 7;
  localparam int PWR_POR    = 1;
  localparam int PWR_BOR    = 0;
  localparam logic [7:0] STATUS_WMASK = 8'he7;
  localparam logic [7:0] TX_CTL_WMASK = 8'hf5;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [7:0] option_config;
    logic [7:0] core_status_flags;
    logic [7:0] indirect_pointer;
    logic [5:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [7:0] port_c_direction;
    logic [4:0] pc_high_latch;
    logic [7:0] interrupt_control;
    logic [7:0] peripheral_irq_enable_one;
    logic [0:0] peripheral_irq_enable_two;
    logic [1:0] power_reset_flags;
    logic [7:0] timer_period;
    logic [7:0] serial_slave_address;
    logic [7:0] serial_tx_control;
    logic [7:0] baud_divisor;
  } sfr_view_t;

endpackage : sfr_bank_pkg

// ===== hdl/indirect_data_memory.sv
// Purpose: Data memory reached through the indirect window
// Assumes: Combinational read, write on clock edge
// Notes:   Contents are not reset
`timescale 1ns/1ps
module indirect_data_memory (
  input  wire logic                            clk,
  input  wire logic                            ce,
  input  wire logic                            wr_en,
  input  wire logic [sfr_bank_pkg::MEM_AW-1:0] addr,
  input  wire logic [7:0]                      wdata,
  output logic      [7:0]                      rdata
);

  logic [7:0] mem [0:(1 << sfr_bank_pkg::MEM_AW)-1];

  always_ff @(posedge clk)
  begin
    if (ce && wr_en)
    begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = mem[addr];

endmodule : indirect_data_memory

// ===== hdl/program_counter_unit.sv
// Purpose: Program counter with upper bits loaded from the high latch
// Assumes: Low byte write loads the whole counter
// Notes:   Upper bits have no direct access path
`timescale 1ns/1ps
module program_counter_unit (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        pcl_write,
  input  wire logic [7:0]  pcl_wdata,
  input  wire logic [4:0]  latch,
  input  wire logic        advance,
  output logic      [12:0] pc
);

  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (rst)
        pc <= sfr_bank_pkg::RST_PC;
      else if (pcl_write)
        pc <= {latch, pcl_wdata};
      else if (advance)
        pc <= pc + 13'h0001;
    end
  end

  property p_pc_load;
    @(posedge clk) disable iff (rst)
    (ce && pcl_write) |=> (pc[12:8] == $past(latch)) && (pc[7:0] == $past(pcl_wdata));
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("pc upper bits not taken from latch");

endmodule : program_counter_unit

// ===== test/test_upper_bank_special_registers.sv
// Purpose: Self-checking bench for the upper special register bank
// Assumes: Zero-wait APB slave, byte address = index * 4
// Notes:   Status bank-select high bits are writable and cleared by every reset
`timescale 1ns/1ps
module test_upper_bank_special_registers;
  logic                    clk;
  logic                    rst;
  logic                    ce;
  logic                    reset_power_class;
  logic                    reset_brownout;
  logic [1:0]              wake_flags;
  logic                    tx_shift_empty;
  logic [5:0]              serial_state;
  logic                    pc_advance;
  sfr_bank_pkg::apb_req_t  apb;
  logic                    pready;
  logic [31:0]             prdata;
  logic                    pslverr;
  logic [12:0]             program_counter;
  sfr_bank_pkg::sfr_view_t sfr;
  int                      num_errors;
  int                      checked;
  logic [7:0]              rd;

  upper_bank_special_registers dut_u (
    .clk               (clk),
    .rst               (rst),
    .ce                (ce),
    .reset_power_class (reset_power_class),
    .reset_brownout    (reset_brownout),
    .wake_flags        (wake_flags),
    .tx_shift_empty    (tx_shift_empty),
    .serial_state      (serial_state),
    .pc_advance        (pc_advance),
    .apb               (apb),
    .pready            (pready),
    .prdata            (prdata),
    .pslverr           (pslverr),
    .program_counter   (program_counter),
    .sfr               (sfr)
  );

  always #25 clk = ~clk;

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask : check

  // One APB transfer, held until pready is seen at a rising edge
  task automatic apb_xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    apb.psel    <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite  <= wr;
    apb.paddr   <= {idx, 2'b00};
    apb.pwdata  <= {24'h000000, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        num_errors++;
        stop_test();
      end
      @(posedge clk);
    end
    rd = prdata[7:0];
    check("prdata upper", {8'h00, prdata[31:8]}, 32'h00000000);
    check("pslverr", {31'h00000000, pslverr}, 32'h00000000);
    apb.psel    <= 1'b0;
    apb.penable <= 1'b0;
  endtask : apb_xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb_xfer(1'b1, idx, d);
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    apb_xfer(1'b0, idx, 8'h00);
    check(name, {24'h000000, rd}, {24'h000000, exp});
  endtask : rd_chk

  task automatic pc_chk(input logic [12:0] exp);
    repeat (2) @(posedge clk);
    #1;
    check("program_counter", {19'h00000, program_counter}, {19'h00000, exp});
  endtask : pc_chk

  task automatic do_reset(input logic pwr, input logic brown);
    @(posedge clk);
    reset_power_class <= pwr;
    reset_brownout    <= brown;
    rst               <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic test_power_values;
    logic [7:0] idx [15] = '{8'h81, 8'h82, 8'h83, 8'h85, 8'h86, 8'h87, 8'h8a, 8'h8b,
                             8'h8c, 8'h8d, 8'h8e, 8'h92, 8'h93, 8'h98, 8'h99};
    logic [7:0] exp [15] = '{8'hff, 8'h00, 8'h18, 8'h3f, 8'hff, 8'hff, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h02, 8'h00};
    foreach (idx[i])
      rd_chk("power reset value", idx[i], exp[i]);
    pc_chk(13'h0000);
  endtask : test_power_values

  task automatic test_unimplemented;
    logic [7:0] hole [14] = '{8'h88, 8'h89, 8'h8f, 8'h90, 8'h91, 8'h95, 8'h96,
                              8'h97, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h9e, 8'h9f};
    foreach (hole[i])
    begin
      wr(hole[i], 8'hff);
      rd_chk("unimplemented", hole[i], 8'h00);
    end
    @(posedge clk) tx_shift_empty <= 1'b0;
    wr(8'h85, 8'hff);
    rd_chk("port a direction", 8'h85, 8'h3f);
    check("sfr port a", {26'h0000000, sfr.port_a_direction}, 32'h0000003f);
    wr(8'h8a, 8'hff);
    rd_chk("pc high latch", 8'h8a, 8'h1f);
    wr(8'h8d, 8'hff);
    rd_chk("irq enable two", 8'h8d, 8'h01);
    wr(8'h8e, 8'hff);
    rd_chk("power flags", 8'h8e, 8'h03);
    wr(8'h98, 8'hff);
    rd_chk("tx control", 8'h98, 8'hf5);
    wr(8'h94, 8'hff);
    rd_chk("serial state", 8'h94, 8'h2a);
    wr(8'h83, 8'h00);
    rd_chk("status", 8'h83, 8'h18);
  endtask : test_unimplemented

  task automatic test_mirrors;
    wr(8'h04, 8'h3c);
    rd_chk("pointer mirror", 8'h84, 8'h3c);
    wr(8'h8a, 8'h0b);
    rd_chk("latch mirror", 8'h0a, 8'h0b);
    wr(8'h0b, 8'h81);
    rd_chk("intctl mirror", 8'h8b, 8'h81);
    wr(8'h03, 8'h21);
    rd_chk("status mirror", 8'h83, 8'h39);
    rd_chk("status lower", 8'h03, 8'h39);
    wr(8'h01, 8'hff);
    rd_chk("lower unmapped", 8'h01, 8'h00);
  endtask : test_mirrors

  task automatic test_pc_latch;
    wr(8'h8a, 8'h15);
    wr(8'h82, 8'h34);
    pc_chk(13'h1534);
    rd_chk("pc low byte", 8'h82, 8'h34);
    wr(8'h8a, 8'h0a);
    pc_chk(13'h1534);
    @(posedge clk) pc_advance <= 1'b1;
    repeat (4) @(posedge clk);
    pc_advance <= 1'b0;
    pc_chk(13'h1538);
    rd_chk("pc low byte", 8'h82, 8'h38);
    // Clock enable low freezes the counter
    @(posedge clk) ce <= 1'b0;
    pc_advance <= 1'b1;
    repeat (3) @(posedge clk);
    ce         <= 1'b1;
    pc_advance <= 1'b0;
    pc_chk(13'h1538);
  endtask : test_pc_latch

  task automatic test_window;
    wr(8'h84, 8'h40);
    wr(8'h80, 8'h5a);
    wr(8'h84, 8'h41);
    wr(8'h80, 8'ha5);
    rd_chk("window", 8'h80, 8'ha5);
    wr(8'h84, 8'h40);
    rd_chk("window", 8'h80, 8'h5a);
    rd_chk("pointer", 8'h84, 8'h40);
  endtask : test_window

  task automatic test_other_reset;
    @(posedge clk) wake_flags <= 2'b01;
    wr(8'h84, 8'h77);
    wr(8'h83, 8'h25);
    wr(8'h8b, 8'h81);
    wr(8'h81, 8'h00);
    wr(8'h8e, 8'h01);
    wr(8'h8a, 8'h1f);
    do_reset(1'b0, 1'b0);
    rd_chk("status", 8'h83, 8'h0d);
    rd_chk("pointer", 8'h84, 8'h77);
    rd_chk("intctl", 8'h8b, 8'h01);
    rd_chk("option", 8'h81, 8'hff);
    rd_chk("power flags", 8'h8e, 8'h01);
    rd_chk("pc high latch", 8'h8a, 8'h00);
    pc_chk(13'h0000);
    wr(8'h8e, 8'h03);
    do_reset(1'b1, 1'b1);
    rd_chk("power flags", 8'h8e, 8'h02);
    check("sfr power flags", {30'h00000000, sfr.power_reset_flags}, 32'h00000002);
    rd_chk("status", 8'h83, 8'h18);
    rd_chk("pointer", 8'h84, 8'h00);
    do_reset(1'b1, 1'b0);
    rd_chk("power flags", 8'h8e, 8'h00);
  endtask : test_other_reset

  initial
  begin
    clk               = 1'b0;
    rst               = 1'b1;
    ce                = 1'b1;
    reset_power_class = 1'b1;
    reset_brownout    = 1'b0;
    wake_flags        = 2'b11;
    tx_shift_empty    = 1'b1;
    serial_state      = 6'h2a;
    pc_advance        = 1'b0;
    apb               = '0;
    num_errors        = 0;
    checked           = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    test_power_values();
    test_unimplemented();
    test_mirrors();
    test_pc_latch();
    test_window();
    test_other_reset();
    stop_test();
  end

  // Cuts a hung handshake short
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule : test_upper_bank_special_registers
